// ### pkg/irpc_pkg.sv
package irpc_pkg;

   // register slots inside the bank
   localparam int          NUM_REGS     = 9;
   localparam logic [3:0]  SLOT_NONE    = 4'hf;
   localparam logic [3:0]  SLOT_PRT     = 4'h0;
   localparam logic [3:0]  SLOT_UART    = 4'h1;
   localparam logic [3:0]  SLOT_FDC_AUX = 4'h2;
   localparam logic [3:0]  SLOT_IR_DMA  = 4'h3;
   localparam logic [3:0]  SLOT_PIN_A   = 4'h4;
   localparam logic [3:0]  SLOT_PIN_B   = 4'h5;
   localparam logic [3:0]  SLOT_FLOPPY  = 4'h6;
   localparam logic [3:0]  SLOT_MISC    = 4'h7;
   localparam logic [3:0]  SLOT_SCI     = 4'h8;

   // index values, slot 8 first
   localparam logic [NUM_REGS-1:0][7:0] REG_INDEX = {
      8'h31, 8'h2e, 8'h2d, 8'h2c, 8'h2b, 8'h2a, 8'h29, 8'h28, 8'h27};
   // reset values with the plug and play default strap high / low
   localparam logic [NUM_REGS-1:0][7:0] RST_STRAP_ON = {
      8'h00, 8'h2e, 8'h00, 8'h10, 8'h00, 8'h00, 8'h62, 8'h43, 8'h05};
   localparam logic [NUM_REGS-1:0][7:0] RST_STRAP_OFF = {
      8'h00, 8'h2e, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   // writable bits; reserved bits hold zero
   localparam logic [NUM_REGS-1:0][7:0] WR_MASK = {
      8'hf4, 8'hff, 8'h3f, 8'hfc, 8'hff, 8'hff, 8'hff, 8'hff, 8'hef};

   // host port select
   localparam logic PORT_INDEX = 1'b0;
   localparam logic PORT_DATA  = 1'b1;

   // field positions
   localparam int HI_MSB     = 7;
   localparam int HI_LSB     = 4;
   localparam int LO_MSB     = 3;
   localparam int LO_LSB     = 0;
   localparam int ECP_MSB    = 7;
   localparam int ECP_LSB    = 5;
   localparam int PIN1_MSB   = 7;
   localparam int PIN1_LSB   = 6;
   localparam int PIN2_MSB   = 5;
   localparam int PIN2_LSB   = 4;
   localparam int PIN3_MSB   = 3;
   localparam int PIN3_LSB   = 2;
   localparam int PIN93_MSB  = 1;
   localparam int PIN93_LSB  = 0;
   localparam int PIN91_MSB  = 7;
   localparam int PIN91_LSB  = 5;
   localparam int CRC_BIT    = 4;
   localparam int BANK_BIT   = 3;
   localparam int CLK48_BIT  = 2;
   localparam int DRA_MSB    = 1;
   localparam int DRA_LSB    = 0;
   localparam int PCA_BIT    = 2;
   localparam int DRB_MSB    = 4;
   localparam int DRB_LSB    = 3;
   localparam int PCB_BIT    = 5;
   localparam int PNF_BIT    = 0;
   localparam int WIDE_N_BIT = 1;
   localparam int READ_DATA_INVERT_BIT  = 2;
   localparam int BURST_BIT  = 3;
   localparam int MODE_BIT   = 2;

   // routing codes
   localparam logic [3:0] SEL_NONE     = 4'h0;
   localparam logic [3:0] SEL_SMI_SLOT = 4'h2;
   localparam int         NUM_PINS     = 8;
   localparam int         NUM_SLOTS    = 16;
   localparam int         NUM_SRC      = 6;

   // sharing-mode low pulse
   localparam int SHARE_PULSE_NS  = 200;
   localparam int CLK_MHZ         = 125;
   localparam int SHARE_PULSE_CYC = (SHARE_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [4:0] SHARE_CNT_LOAD = 5'(SHARE_PULSE_CYC);

   typedef enum logic [3:0] {
      PF_IRQ_G       = 4'h0,
      PF_RESERVED    = 4'h1,
      PF_DMA_REQ_D   = 4'h2,
      PF_IR_SEL2     = 4'h3,
      PF_PCI_CLK     = 4'h4,
      PF_CHIP_SELECT = 4'h5,
      PF_ADDR11      = 4'h6,
      PF_POWER_DOWN  = 4'h7,
      PF_DMA_ACK_D   = 4'h8,
      PF_IR_SEL1     = 4'h9,
      PF_IR_FAST_RX  = 4'ha,
      PF_IR_SEL0     = 4'hb,
      PF_AUX_IRQ_IN  = 4'hc,
      PF_PNF         = 4'hd,
      PF_IRQ_H       = 4'he,
      PF_SERIAL_IRQ  = 4'hf
   } irpc_pin_func_t;

   typedef enum logic [2:0] {
      RATE_NONE = 3'h0,
      RATE_125K = 3'h1,
      RATE_150K = 3'h2,
      RATE_250K = 3'h3,
      RATE_300K = 3'h4,
      RATE_500K = 3'h5,
      RATE_1M   = 3'h6,
      RATE_2M   = 3'h7
   } irpc_rate_t;

endpackage

// ### design/irpc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module irpc_regs
   import irpc_pkg::*;
(
   input  wire logic                 clk_in,
   input  wire logic                 rst_n_in,
   input  wire logic                 ext_mode_in,
   input  wire logic                 cfg_wr_in,
   input  wire logic                 cfg_rd_in,
   input  wire logic                 cfg_port_in,
   input  wire logic [7:0]           cfg_wdata_in,
   input  wire logic                 plugplay_default_select_in,
   input  wire logic                 parallel_irq_in,
   input  wire logic                 serial_a_irq_in,
   input  wire logic                 serial_b_irq_in,
   input  wire logic                 floppy_irq_in,
   input  wire logic                 aux_interrupt_input_in,
   input  wire logic                 sci_irq_in,
   input  wire logic [NUM_PINS-1:0]  share_mode_in,
   input  wire logic                 ir_sel0_mode_in,
   input  wire logic [1:0]           rate_select_in,
   input  wire logic                 fm_mode_in,
   output logic [7:0]                cfg_rdata_out,
   output logic [NUM_PINS-1:0]       irq_pin_out,
   output logic [NUM_PINS-1:0]       irq_pin_oe_n_out,
   output logic [NUM_SLOTS-1:0]      serirq_slot_req_out,
   output logic                      serial_interrupt_mode_out,
   output logic [2:0]                ecp_irq_code_out,
   output irpc_pin_func_t            pin1_function_out,
   output irpc_pin_func_t            pin2_function_out,
   output irpc_pin_func_t            pin3_function_out,
   output irpc_pin_func_t            pin93_function_out,
   output irpc_pin_func_t            pin91_function_out,
   output logic [3:0]                ir_tx_dma_select_out,
   output logic [3:0]                ir_rx_dma_select_out,
   output logic                      append_crc_enable_out,
   output logic                      serial_b_bank_enable_out,
   output logic                      input_clock_48m_out,
   output irpc_rate_t                drive_a_rate_out,
   output irpc_rate_t                drive_b_rate_out,
   output logic                      drive_a_precomp_en_out,
   output logic                      drive_b_precomp_en_out,
   output logic                      wide_decode_enable_out,
   output logic                      serial_b_ir_mode_out,
   output logic                      read_data_invert_out,
   output logic                      floppy_burst_disable_out,
   output logic                      printer_not_floppy_enable_out
);

   // index to bank slot, SLOT_NONE when unmapped
   function automatic logic [3:0] slot_of(input logic [7:0] idx);
      logic [3:0] s;
      s = SLOT_NONE;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (REG_INDEX[i] == idx) begin
            s = 4'(i);
         end
      end
      return s;
   endfunction

   // drive rate from table bits, rate select and encoding
   function automatic irpc_rate_t rate_of(input logic [1:0] tbl,
                                          input logic [1:0] drate,
                                          input logic       fm);
      irpc_rate_t r;
      r = RATE_NONE;
      unique case (drate)
         2'h3: r = RATE_1M;
         2'h0: r = RATE_500K;
         2'h2: r = RATE_250K;
         2'h1: begin
            unique case (tbl)
               2'h0: r = RATE_300K;
               2'h1: r = RATE_500K;
               2'h2: r = RATE_2M;
               2'h3: r = RATE_NONE;
            endcase
         end
      endcase
      if (fm) begin
         unique case (r)
            RATE_500K: r = RATE_250K;
            RATE_300K: r = RATE_150K;
            RATE_250K: r = RATE_125K;
            default:   r = RATE_NONE;
         endcase
      end
      return r;
   endfunction

   // choice between IR select 0 and fast receive
   function automatic irpc_pin_func_t sel0_or_rx(input logic mode);
      return mode ? PF_IR_SEL0 : PF_IR_FAST_RX;
   endfunction

   logic [7:0]                index_r;
   logic [NUM_REGS-1:0][7:0]  cfg_r;
   logic                      strap_s1_r;
   logic                      strap_s2_r;
   logic                      strap_prev_r;
   logic                      aux_s1_r;
   logic                      aux_s2_r;
   logic [3:0]                wr_slot;
   logic [3:0]                rd_slot;
   logic                      data_wr;
   logic                      reload;
   logic                      serial_mode;
   logic [NUM_SRC-1:0]        src_req;
   logic [NUM_SRC-1:0][3:0]   src_sel;
   logic [NUM_PINS-1:0]       pin_req;
   logic [NUM_PINS-1:0]       pin_used;
   logic [NUM_PINS-1:0]       pin_req_prev_r;
   logic [NUM_SLOTS-1:0]      slot_nxt;

   // strap and aux pin come from outside, two flops before use
   always_ff @(posedge clk_in) begin
      strap_s1_r <= plugplay_default_select_in;
      strap_s2_r <= strap_s1_r;
      aux_s1_r   <= aux_interrupt_input_in;
      aux_s2_r   <= aux_s1_r;
   end

   // strap edge tracker; a complementary change reloads defaults
   always_ff @(posedge clk_in) begin
      strap_prev_r <= strap_s2_r;
   end
   assign reload = (strap_prev_r != strap_s2_r);

   // host access only in extended function mode
   assign data_wr = ext_mode_in && cfg_wr_in && (cfg_port_in == PORT_DATA);
   assign wr_slot = slot_of(index_r);
   assign rd_slot = wr_slot;

   // index port
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         index_r <= 8'h00;
      end else if (ext_mode_in && cfg_wr_in &&
                   (cfg_port_in == PORT_INDEX)) begin
         index_r <= cfg_wdata_in;
      end
   end

   // register bank; strap picks the allocation defaults
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || reload) begin
         cfg_r <= strap_s2_r ? RST_STRAP_ON : RST_STRAP_OFF;
      end else if (data_wr && (wr_slot != SLOT_NONE)) begin
         cfg_r[wr_slot] <= cfg_wdata_in & WR_MASK[wr_slot];
      end
   end

   // read data; unmapped index reads zero
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cfg_rdata_out <= 8'h00;
      end else if (ext_mode_in && cfg_rd_in) begin
         if (cfg_port_in == PORT_INDEX) begin
            cfg_rdata_out <= index_r;
         end else if (rd_slot == SLOT_NONE) begin
            cfg_rdata_out <= 8'h00;
         end else begin
            cfg_rdata_out <= cfg_r[rd_slot];
         end
      end
   end

   // interrupt sources and their routing fields
   assign serial_mode = cfg_r[SLOT_SCI][MODE_BIT];
   assign src_req = {sci_irq_in, aux_s2_r, floppy_irq_in,
                     serial_b_irq_in, serial_a_irq_in, parallel_irq_in};
   assign src_sel[0] = cfg_r[SLOT_PRT][LO_MSB:LO_LSB];
   assign src_sel[1] = cfg_r[SLOT_UART][HI_MSB:HI_LSB];
   assign src_sel[2] = cfg_r[SLOT_UART][LO_MSB:LO_LSB];
   assign src_sel[3] = cfg_r[SLOT_FDC_AUX][HI_MSB:HI_LSB];
   assign src_sel[4] = cfg_r[SLOT_FDC_AUX][LO_MSB:LO_LSB];
   assign src_sel[5] = cfg_r[SLOT_SCI][HI_MSB:HI_LSB];

   // per pin: which sources land here, codes 1..8 only
   always_comb begin
      pin_req  = '0;
      pin_used = '0;
      for (int p = 0; p < NUM_PINS; p++) begin
         for (int s = 0; s < NUM_SRC; s++) begin
            if (src_sel[s] == 4'(p + 1)) begin
               pin_used[p] = 1'b1;
               pin_req[p]  = pin_req[p] | src_req[s];
            end
         end
      end
   end

   // serial frame slots; 0 none, slot 2 left to SMI
   always_comb begin
      slot_nxt = '0;
      for (int s = 0; s < NUM_SRC; s++) begin
         if (src_sel[s] != SEL_NONE && src_sel[s] != SEL_SMI_SLOT) begin
            slot_nxt[src_sel[s]] = slot_nxt[src_sel[s]] | src_req[s];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         serirq_slot_req_out <= '0;
      end else begin
         serirq_slot_req_out <= serial_mode ? slot_nxt : '0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pin_req_prev_r <= '0;
      end else begin
         pin_req_prev_r <= pin_req;
      end
   end

   // pin drivers; a sharing pin only pulls low for a fixed pulse
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_pin
         logic [4:0] pulse_cnt_r;
         always_ff @(posedge clk_in) begin
            if (!rst_n_in || serial_mode || !share_mode_in[g]) begin
               pulse_cnt_r <= 5'h00;
            end else if (pin_req[g] && !pin_req_prev_r[g]) begin
               pulse_cnt_r <= SHARE_CNT_LOAD;
            end else if (pulse_cnt_r != 5'h00) begin
               pulse_cnt_r <= pulse_cnt_r - 5'h01;
            end
         end
         always_ff @(posedge clk_in) begin
            if (!rst_n_in || serial_mode) begin
               irq_pin_out[g]      <= 1'b0;
               irq_pin_oe_n_out[g] <= 1'b1;
            end else if (share_mode_in[g]) begin
               // request edge starts the pulse in the same cycle
               irq_pin_out[g]      <= 1'b0;
               irq_pin_oe_n_out[g] <= !((pin_req[g] && !pin_req_prev_r[g])
                                        || (pulse_cnt_r > 5'h01));
            end else begin
               irq_pin_out[g]      <= pin_req[g];
               irq_pin_oe_n_out[g] <= !pin_used[g];
            end
         end
      end
   endgenerate

   // shared pin functions
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pin1_function_out  <= PF_IRQ_G;
         pin2_function_out  <= PF_CHIP_SELECT;
         pin3_function_out  <= PF_POWER_DOWN;
         pin93_function_out <= PF_AUX_IRQ_IN;
         pin91_function_out <= PF_IRQ_H;
      end else begin
         if (serial_mode) begin
            pin1_function_out <= PF_PCI_CLK;
         end else begin
            unique case (cfg_r[SLOT_PIN_A][PIN1_MSB:PIN1_LSB])
               2'h0: pin1_function_out <= PF_IRQ_G;
               2'h1: pin1_function_out <= PF_RESERVED;
               2'h2: pin1_function_out <= PF_DMA_REQ_D;
               2'h3: pin1_function_out <= PF_IR_SEL2;
            endcase
         end
         unique case (cfg_r[SLOT_PIN_A][PIN2_MSB:PIN2_LSB])
            2'h0:    pin2_function_out <= PF_CHIP_SELECT;
            2'h1:    pin2_function_out <= PF_ADDR11;
            default: pin2_function_out <= PF_RESERVED;
         endcase
         unique case (cfg_r[SLOT_PIN_A][PIN3_MSB:PIN3_LSB])
            2'h0: pin3_function_out <= PF_POWER_DOWN;
            2'h1: pin3_function_out <= PF_DMA_ACK_D;
            2'h2: pin3_function_out <= PF_IR_SEL1;
            2'h3: pin3_function_out <= sel0_or_rx(ir_sel0_mode_in);
         endcase
         if (cfg_r[SLOT_MISC][PNF_BIT]) begin
            pin93_function_out <= PF_PNF;
         end else begin
            unique case (cfg_r[SLOT_PIN_A][PIN93_MSB:PIN93_LSB])
               2'h0: pin93_function_out <= PF_AUX_IRQ_IN;
               2'h1: pin93_function_out <= PF_DMA_REQ_D;
               2'h2: pin93_function_out <= PF_IR_SEL2;
               2'h3: pin93_function_out <= sel0_or_rx(ir_sel0_mode_in);
            endcase
         end
         if (serial_mode) begin
            pin91_function_out <= PF_SERIAL_IRQ;
         end else begin
            unique case (cfg_r[SLOT_PIN_B][PIN91_MSB:PIN91_LSB])
               3'h0:    pin91_function_out <= PF_IRQ_H;
               3'h2:    pin91_function_out <= PF_IR_SEL2;
               3'h4:    pin91_function_out <= PF_DMA_ACK_D;
               default: pin91_function_out <= PF_RESERVED;
            endcase
         end
      end
   end

   // infrared, clock and decode options
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ir_tx_dma_select_out          <= 4'h0;
         ir_rx_dma_select_out          <= 4'h0;
         append_crc_enable_out         <= 1'b0;
         serial_b_bank_enable_out      <= 1'b0;
         input_clock_48m_out           <= 1'b0;
         wide_decode_enable_out        <= 1'b0;
         serial_b_ir_mode_out          <= 1'b0;
         read_data_invert_out          <= 1'b0;
         floppy_burst_disable_out      <= 1'b0;
         printer_not_floppy_enable_out <= 1'b0;
         serial_interrupt_mode_out     <= 1'b0;
         ecp_irq_code_out              <= 3'h0;
      end else begin
         ir_tx_dma_select_out  <= cfg_r[SLOT_IR_DMA][HI_MSB:HI_LSB];
         ir_rx_dma_select_out  <= cfg_r[SLOT_IR_DMA][LO_MSB:LO_LSB];
         append_crc_enable_out <= cfg_r[SLOT_PIN_B][CRC_BIT];
         serial_b_bank_enable_out <= cfg_r[SLOT_PIN_B][BANK_BIT];
         input_clock_48m_out   <= cfg_r[SLOT_PIN_B][CLK48_BIT];
         // decode bit is active low
         wide_decode_enable_out <= !cfg_r[SLOT_MISC][WIDE_N_BIT];
         serial_b_ir_mode_out   <= !cfg_r[SLOT_MISC][WIDE_N_BIT];
         read_data_invert_out   <= cfg_r[SLOT_MISC][READ_DATA_INVERT_BIT];
         floppy_burst_disable_out <= cfg_r[SLOT_MISC][BURST_BIT];
         printer_not_floppy_enable_out <= cfg_r[SLOT_MISC][PNF_BIT];
         serial_interrupt_mode_out <= serial_mode;
         ecp_irq_code_out <= cfg_r[SLOT_PRT][ECP_MSB:ECP_LSB];
      end
   end

   // floppy data rate and precompensation
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         drive_a_rate_out       <= RATE_NONE;
         drive_b_rate_out       <= RATE_NONE;
         drive_a_precomp_en_out <= 1'b0;
         drive_b_precomp_en_out <= 1'b0;
      end else begin
         drive_a_rate_out <= rate_of(cfg_r[SLOT_FLOPPY][DRA_MSB:DRA_LSB],
                                     rate_select_in, fm_mode_in);
         drive_b_rate_out <= rate_of(cfg_r[SLOT_FLOPPY][DRB_MSB:DRB_LSB],
                                     rate_select_in, fm_mode_in);
         drive_a_precomp_en_out <= !cfg_r[SLOT_FLOPPY][PCA_BIT];
         drive_b_precomp_en_out <= !cfg_r[SLOT_FLOPPY][PCB_BIT];
      end
   end

endmodule
`default_nettype wire

// ### bench/irpc_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module irpc_regs_chk
   import irpc_pkg::*;
(
   input wire logic                 clk_in,
   input wire logic                 rst_n_in,
   input wire logic                 ext_mode_in,
   input wire logic                 cfg_rd_in,
   input wire logic                 fm_mode_in,
   input wire logic [NUM_PINS-1:0]  share_mode_in,
   input wire logic [7:0]           cfg_rdata_out,
   input wire logic [NUM_PINS-1:0]  irq_pin_out,
   input wire logic [NUM_PINS-1:0]  irq_pin_oe_n_out,
   input wire logic [NUM_SLOTS-1:0] serirq_slot_req_out,
   input wire logic                 serial_interrupt_mode_out,
   input wire irpc_pin_func_t       pin1_function_out,
   input wire irpc_pin_func_t       pin91_function_out,
   input wire irpc_rate_t           drive_a_rate_out,
   input wire logic                 wide_decode_enable_out,
   input wire logic                 serial_b_ir_mode_out
);
   logic [7:0] low_cnt_r;
   // low stretch on pin a; saturates so long legacy levels cannot wrap
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || irq_pin_oe_n_out[0]) low_cnt_r <= 8'h00;
      else if (low_cnt_r != 8'hff) low_cnt_r <= low_cnt_r + 8'h01;
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // mode held two samples, so derived outputs have caught up
   sequence s_serial_on;
      serial_interrupt_mode_out && $past(serial_interrupt_mode_out);
   endsequence
   pins_float_a: assert property (s_serial_on |-> &irq_pin_oe_n_out)
      else $error("irq pin driven in serial mode");
   slot_reserved_a: assert property (!serirq_slot_req_out[0] &&
      !serirq_slot_req_out[2]) else $error("reserved slot requested");
   pin1_pciclk_a: assert property (s_serial_on |->
      pin1_function_out == PF_PCI_CLK) else $error("pin 1 not pci clock");
   pin91_serirq_a: assert property (s_serial_on |->
      pin91_function_out == PF_SERIAL_IRQ) else $error("pin 91 not serial");
   rdata_hold_a: assert property ((!cfg_rd_in || !ext_mode_in) |=>
      $stable(cfg_rdata_out)) else $error("read data moved without read");
   share_width_a: assert property (share_mode_in[0] &&
      $rose(irq_pin_oe_n_out[0]) |-> low_cnt_r == 8'h19)
      else $error("sharing pulse width wrong");
   share_low_a: assert property (share_mode_in[0] &&
      !irq_pin_oe_n_out[0] |-> !irq_pin_out[0])
      else $error("sharing pulse not low");
   fm_rate_a: assert property (fm_mode_in && $past(fm_mode_in) |->
      !(drive_a_rate_out inside {RATE_1M, RATE_2M}))
      else $error("fm at fast rate");
   wide_ir_a: assert property (wide_decode_enable_out |->
      serial_b_ir_mode_out) else $error("serial b not infrared");
endmodule
`default_nettype wire

// ### bench/irpc_host_irq.sv
`timescale 1ns/1ps
`default_nettype none
module irpc_host_irq (
   input  wire logic [7:0] pin_in,
   input  wire logic [7:0] oe_n_in,
   output logic [7:0]      line_out
);
   // bus lines carry pull-ups: a floating pin reads high, never stale
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         line_out[i] = oe_n_in[i] ? 1'b1 : pin_in[i];
      end
   end
endmodule
`default_nettype wire

// ### bench/irq_routing_pin_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module irq_routing_pin_config_regs_tb import irpc_pkg::*;;
   logic clk_in, rst_n_in, ext_mode_in, cfg_wr_in, cfg_rd_in, cfg_port_in;
   logic parallel_irq_in, sci_irq_in, ir_sel0_mode_in, fm_mode_in, strap;
   logic [7:0]     cfg_wdata_in, cfg_rdata_out, share_mode_in, line, ird;
   logic [7:0]     irq_pin_out, irq_pin_oe_n_out;
   logic [1:0]     rate_select_in, md;
   logic [2:0]     ecp, pb;
   logic [15:0]    serirq_slot_req_out, e;
   logic           serial_interrupt_mode_out, wide_decode_enable_out;
   logic           serial_b_ir_mode_out, printer_not_floppy_enable_out;
   logic           drive_a_precomp_en_out, drive_b_precomp_en_out;
   irpc_pin_func_t pin1_function_out, pin2_function_out, pin3_function_out;
   irpc_pin_func_t pin93_function_out, pin91_function_out;
   irpc_rate_t     drive_a_rate_out, drive_b_rate_out;
   int             n_mismatch, num_checks;
   logic [7:0] ix[9] = '{8'h27,8'h28,8'h29,8'h2a,8'h2b,8'h2c,8'h2d,8'h2e,
      8'h31};
   logic [7:0] rv[9] = '{8'h05,8'h43,8'h62,8'h00,8'h00,8'h10,8'h00,8'h2e,
      8'h00};
   logic [7:0] mk[9] = '{8'hef,8'hff,8'hff,8'hff,8'hff,8'hfc,8'h3f,8'hff,
      8'hf4};
   logic [2:0] rt[12] = '{5,4,3,6, 5,5,3,6, 5,7,3,6};
   logic [15:0] pf[4] = '{16'h057c, 16'h1682, 16'h2193, 16'h31bb};
   irpc_regs u_dut (.clk_in, .rst_n_in, .ext_mode_in, .cfg_wr_in, .cfg_rd_in,
      .cfg_port_in, .cfg_wdata_in, .plugplay_default_select_in(strap),
      .parallel_irq_in, .serial_a_irq_in(1'b0), .serial_b_irq_in(1'b0),
      .floppy_irq_in(sci_irq_in), .aux_interrupt_input_in(1'b0), .sci_irq_in,
      .share_mode_in, .ir_sel0_mode_in, .rate_select_in, .fm_mode_in,
      .cfg_rdata_out, .irq_pin_out, .irq_pin_oe_n_out, .serirq_slot_req_out,
      .serial_interrupt_mode_out, .ecp_irq_code_out(ecp), .pin1_function_out,
      .pin2_function_out, .pin3_function_out, .pin93_function_out,
      .pin91_function_out, .ir_tx_dma_select_out(ird[7:4]),
      .ir_rx_dma_select_out(ird[3:0]), .append_crc_enable_out(pb[2]),
      .serial_b_bank_enable_out(pb[1]), .input_clock_48m_out(pb[0]),
      .drive_a_rate_out, .drive_b_rate_out, .drive_a_precomp_en_out,
      .drive_b_precomp_en_out, .wide_decode_enable_out, .serial_b_ir_mode_out,
      .read_data_invert_out(md[1]), .floppy_burst_disable_out(md[0]),
      .printer_not_floppy_enable_out);
   irpc_host_irq u_host (.pin_in(irq_pin_out), .oe_n_in(irq_pin_oe_n_out),
      .line_out(line));
   // clock 125 MHz
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] x, g);
      num_checks++;
      if (x !== g) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, x, g);
      end
   endtask
   // index then data, as the host must order them
   task automatic wr(input logic [7:0] i, d);
      @(posedge clk_in);
      cfg_wr_in    <= 1'b1;
      cfg_port_in  <= PORT_INDEX;
      cfg_wdata_in <= i;
      @(posedge clk_in);
      cfg_port_in  <= PORT_DATA;
      cfg_wdata_in <= d;
      @(posedge clk_in);
      cfg_wr_in    <= 1'b0;
      repeat (3) @(negedge clk_in); // derived outputs lag one cycle
   endtask
   task automatic rd(input logic [7:0] i, x);
      @(posedge clk_in);
      cfg_wr_in    <= 1'b1;
      cfg_port_in  <= PORT_INDEX;
      cfg_wdata_in <= i;
      @(posedge clk_in);
      cfg_wr_in    <= 1'b0;
      cfg_rd_in    <= 1'b1;
      cfg_port_in  <= PORT_DATA;
      @(posedge clk_in);
      cfg_rd_in    <= 1'b0;
      @(negedge clk_in);
      chk("rdata", {8'h00, x}, {8'h00, cfg_rdata_out});
   endtask
   task automatic drv(input logic p, s, input logic [1:0] r, input logic f);
      @(posedge clk_in);
      parallel_irq_in <= p;
      sci_irq_in      <= s;
      rate_select_in  <= r;
      fm_mode_in      <= f;
      repeat (3) @(negedge clk_in);
   endtask
   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #200us;
      n_mismatch++;
      complete_run();
   end
   initial begin
      {rst_n_in, cfg_wr_in, cfg_rd_in, cfg_port_in, cfg_wdata_in} = '0;
      {parallel_irq_in, sci_irq_in, fm_mode_in, rate_select_in} = '0;
      {n_mismatch, num_checks, share_mode_in} = '0;
      ext_mode_in = 1'b1;
      {ir_sel0_mode_in, strap} = 2'b11;
      repeat (4) @(posedge clk_in);
      rst_n_in <= 1'b1;
      for (int k = 0; k < 9; k++) rd(ix[k], rv[k]);
      @(posedge clk_in) ext_mode_in <= 1'b0;
      wr(8'h2b, 8'hff);
      @(posedge clk_in) ext_mode_in <= 1'b1;
      rd(8'h2b, 8'h00);
      wr(8'h30, 8'hff);
      rd(8'h30, 8'h00);
      for (int k = 0; k < 9; k++) begin
         wr(ix[k], 8'hff);
         rd(ix[k], mk[k]);
         wr(ix[k], 8'h00);
      end
      wr(8'h2a, 8'h5c);
      wr(8'h2c, 8'h0c);
      wr(8'h27, 8'ha0);
      wr(8'h2e, 8'h08);
      chk("opts", 16'hab8d, {ecp, ird, pb, md});
      // same code into all four fields of the pin register
      for (int c = 0; c < 4; c++) begin
         wr(8'h2b, 8'(c * 8'h55));
         e = pf[c];
         chk("pins", e, {pin1_function_out, pin2_function_out,
            pin3_function_out, pin93_function_out});
      end
      @(posedge clk_in) ir_sel0_mode_in <= 1'b0;
      wr(8'h2e, 8'h01);
      chk("pnf", 16'h0da7, {pin93_function_out, pin3_function_out, 1'b0,
         printer_not_floppy_enable_out, wide_decode_enable_out,
         serial_b_ir_mode_out});
      for (int t = 0; t < 3; t++) begin
         wr(8'h2d, 8'(t * 9 + 4));
         for (int s = 0; s < 4; s++) begin
            drv(1'b0, 1'b0, 2'(s), 1'b0);
            chk("rate", {7'h00, rt[t*4+s], rt[t*4+s], 2'b01},
               {7'h00, drive_a_rate_out, drive_b_rate_out,
               drive_a_precomp_en_out, drive_b_precomp_en_out});
         end
      end
      drv(1'b0, 1'b0, 2'b01, 1'b1);
      chk("fm", 16'(RATE_NONE), 16'(drive_a_rate_out));
      drv(1'b0, 1'b0, 2'b00, 1'b1);
      chk("fm", 16'(RATE_250K), 16'(drive_a_rate_out));
      wr(8'h27, 8'h08);
      drv(1'b1, 1'b0, 2'b00, 1'b0);
      chk("oe", 16'h7fff, {irq_pin_oe_n_out, line});
      drv(1'b0, 1'b0, 2'b00, 1'b0);
      chk("line", 16'h7f7f, {irq_pin_oe_n_out, line});
      wr(8'h31, 8'h10);
      wr(8'h29, 8'h20);
      drv(1'b0, 1'b1, 2'b00, 1'b0);
      chk("sci", 16'h7c7f, {irq_pin_oe_n_out, line});
      wr(8'h31, 8'h14);
      wr(8'h27, 8'h0f);
      drv(1'b1, 1'b1, 2'b00, 1'b0);
      chk("slots", 16'h8002, serirq_slot_req_out);
      chk("float", 16'h00ff, {8'h00, irq_pin_oe_n_out});
      chk("pfun", 16'h004f,
         {8'h00, pin1_function_out, pin91_function_out});
      wr(8'h27, 8'h02);
      chk("slots", 16'h0002, serirq_slot_req_out);
      wr(8'h31, 8'h00);
      drv(1'b0, 1'b0, 2'b00, 1'b0);
      @(posedge clk_in) share_mode_in <= 8'h01;
      wr(8'h27, 8'h01);
      drv(1'b1, 1'b0, 2'b00, 1'b0);
      chk("share", 16'h0000, {15'h0000, irq_pin_oe_n_out[0]});
      repeat (28) @(negedge clk_in);
      chk("share", 16'h0003, {14'h0000, irq_pin_oe_n_out[0], line[0]});
      // strap flipped low: allocation defaults reload as zero
      @(posedge clk_in) strap <= 1'b0;
      repeat (4) @(posedge clk_in);
      rd(8'h27, 8'h00);
      rd(8'h2c, 8'h10);
      complete_run();
   end
endmodule
bind irpc_regs irpc_regs_chk u_chk (.clk_in, .rst_n_in, .ext_mode_in,
   .cfg_rd_in, .fm_mode_in, .share_mode_in, .cfg_rdata_out, .irq_pin_out,
   .irq_pin_oe_n_out, .serirq_slot_req_out, .serial_interrupt_mode_out,
   .pin1_function_out, .pin91_function_out, .drive_a_rate_out,
   .wide_decode_enable_out, .serial_b_ir_mode_out);
`default_nettype wire
